// ===== src/ppp_consts.svh
// Purpose: Constants of the parallel programming port: commands, actions, sizes, timing.
// Assumes: A 200 MHz core clock.
// Notes: Definitions only.
`ifndef PPP_CONSTS_SVH
`define PPP_CONSTS_SVH
`define PPP_CMD_NOP 8'h00
`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WR_FUSE 8'h40
`define PPP_CMD_WR_LOCK 8'h20
`define PPP_CMD_WR_FLASH 8'h10
`define PPP_CMD_WR_EEPROM 8'h11
`define PPP_CMD_RD_SIG 8'h08
`define PPP_CMD_RD_FUSE 8'h04
`define PPP_CMD_RD_FLASH 8'h02
`define PPP_CMD_RD_EEPROM 8'h03
`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
`define PPP_PINS_IDLE 16'hC600
`define PPP_FLASH_WORDS 4096
`define PPP_FLASH_PAGE_BITS 5
`define PPP_EEPROM_BYTES 512
`define PPP_EEPROM_PAGE_BITS 2
`define PPP_PRESERVE_BIT 3
`define PPP_FIFO_DEPTH 16
`define PPP_CLK_MHZ 200.0
`define PPP_WRITE_MIN_MS 3.7
`define PPP_WRITE_MAX_MS 4.5
`define PPP_ERASE_MIN_MS 7.5
`define PPP_ERASE_MAX_MS 9.0
`define PPP_ERASED_WORD 16'hFFFF
`define PPP_ERASED_BYTE 8'hFF
`endif

// ===== src/ppp_pkg.sv
// Purpose: Types shared by the parallel programming port.
// Assumes: Nothing beyond the constants header.
// Notes: Pin group and page entry travel as packed structs.
package ppp_pkg;
   typedef enum {ST_IDLE, ST_DRAIN, ST_PROG, ST_ERASE} state_t;
   typedef struct packed {
      logic actHi;
      logic actLo;
      logic selLoHi;
      logic selSecond;
      logic pageLatch;
      logic write_n;
      logic outEnable_n;
      logic loadClock;
      logic [7:0] data;
   } pins_t;
   typedef struct packed {
      logic [4:0] index;
      logic [15:0] word;
   } pageEntry_t;
endpackage

// ===== src/ppp_fifo.sv
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Full and empty come straight from the occupancy count.
`timescale 1ns/10ps
module ppp_fifo #(
   parameter int WIDTH = 21,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("FIFO depth must be a power of two of at least 2.");
   end
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [AW:0] count;
   logic push;
   logic pop;

   // Handshakes are combinational; the stored word is a flip-flop array.
   assign inReady = (count != (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData = store[rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   // Pointers and occupancy.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (push) wrPtr <= wrPtr + AW'(1);
         if (pop) rdPtr <= rdPtr + AW'(1);
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   // Storage has no reset.
   always_ff @(posedge clk) begin
      if (push) store[wrPtr] <= inData;
   end
endmodule

// ===== src/parallel_program_port.sv
// Summary of operation
// R1: Command and address registers hold until reloaded, serving many accesses.
// R2: Programmer reloads the address high byte only when changing 256 window.
// R3: Chip erase clears flash, eeprom and lock bits; fuses stay unchanged.
// R4: Lock bits stay set until the whole flash erase walk completes.
// R5: Programmed eeprom preserve fuse keeps eeprom contents through chip erase.
// R6: Action 10 with low byte select loads the command byte; 80h erases.
// R7: Write strobe after erase command starts erase and drops ready flag.
// R8: Command 10h is flash write through the page buffer.
// R9: Action 00 loads address low or high byte by byte select.
// R10: Action 01 loads data low or high byte by byte select.
// R11: Page latch with byte select high stores data at current word index.
// R12: Low address bits pick page word; upper bits pick page at commit.
// R13: Write strobe with byte select low programs buffered flash page, busy meanwhile.
// R14: Command 00h is a no-operation clearing write state.
// R15: Command 11h writes eeprom pages from latched bytes on write strobe.
// R16: Command 02h reads flash low or high byte with output enable low.
// R17: Command 03h reads the addressed eeprom byte.
// R18: Command 40h writes low or high fuse byte from data low byte.
// R19: Command 20h programs lock bits where data is zero; only erase clears.
// R20: Command 04h reads low fuse, high fuse or lock bits by selects.
// R21: Command 08h reads identification byte 0 to 2 by address low byte.
// R22: Same command with byte select high reads the calibration byte.
// R23: Ready flag is low during program or erase, high when ready.
// R24: Data bus is driven only while output enable is low.
// R25: Write busy lasts between 3.7 and 4.5 ms.
// R26: Erase busy lasts between 7.5 and 9 ms.
// R27: Strobes are ignored while the ready flag is low.
// R28: Action 11 is idle; page buffer kept until programmed or command load.
// Purpose: Parallel programming port with flash, eeprom, fuse and lock storage.
// Assumes: Pins are asynchronous to clk; pulses last several clock periods.
// Notes: Page latches pass a FIFO before reaching the page buffer.
`timescale 1ns/10ps
`include "ppp_consts.svh"
module parallel_program_port import ppp_pkg::*; #(
   parameter int WRITE_CYCLES = int'($ceil(`PPP_WRITE_MIN_MS * `PPP_CLK_MHZ * 1000.0)),
   parameter int ERASE_CYCLES = int'($ceil(`PPP_ERASE_MIN_MS * `PPP_CLK_MHZ * 1000.0)),
   parameter logic [7:0] FUSE_LO_RESET = 8'hFF,
   parameter logic [7:0] FUSE_HI_RESET = 8'hFF,
   parameter logic [7:0] LOCK_RESET = 8'hFF,
   parameter logic [7:0] ID_BYTE0 = 8'hA5,  // Arbitrary identification value.
   parameter logic [7:0] ID_BYTE1 = 8'h5A,  // Arbitrary identification value.
   parameter logic [7:0] ID_BYTE2 = 8'h3C,  // Arbitrary identification value.
   parameter logic [7:0] CAL_BYTE = 8'h80
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic actionSelectHi,
   input wire logic actionSelectLo,
   input wire logic byteSelectLoHi,
   input wire logic byteSelectSecond,
   input wire logic pageLatchStrobe,
   input wire logic write_n,
   input wire logic outputEnable_n,
   input wire logic loadClockPin,
   input wire logic [7:0] dataIn,
   output logic [7:0] dataOut,
   output logic dataOe,
   output logic readyBusyFlag
);
   localparam int WRITE_MAX = int'($floor(`PPP_WRITE_MAX_MS * `PPP_CLK_MHZ * 1000.0));
   localparam int ERASE_MAX = int'($floor(`PPP_ERASE_MAX_MS * `PPP_CLK_MHZ * 1000.0));
   localparam int PAGE_WORDS = 1 << `PPP_FLASH_PAGE_BITS;
   if (WRITE_CYCLES <= PAGE_WORDS || ERASE_CYCLES <= `PPP_FLASH_WORDS
       || WRITE_CYCLES >= (1 << 21) || ERASE_CYCLES >= (1 << 21)) begin : g_bad_time
      $error("Busy counts must exceed the memory walks and fit 21 bits.");
   end

   pins_t pinsRaw;
   pins_t sync1;
   pins_t sync2;
   pins_t prev;
   state_t state;
   logic [7:0] command;
   logic [7:0] addrLo;
   logic [7:0] addrHi;
   logic [7:0] dataLo;
   logic [7:0] dataHi;
   logic [7:0] fuseLo;
   logic [7:0] fuseHi;
   logic [7:0] lockBits;
   logic [15:0] flashMem [`PPP_FLASH_WORDS];
   logic [7:0] eepromMem [`PPP_EEPROM_BYTES];
   logic [15:0] pageBuf [PAGE_WORDS];
   logic [PAGE_WORDS-1:0] pageValid;
   logic [20:0] timer;
   logic [11:0] walkIdx;
   logic walkDone;
   logic isEeprom;
   logic loadEvt;
   logic latchEvt;
   logic writeEvt;
   logic idle;
   logic [1:0] action;
   logic [15:0] fullAddr;
   pageEntry_t fifoIn;
   pageEntry_t fifoOut;
   logic fifoInReady;
   logic fifoOutValid;
   logic fifoOutReady;
   logic [7:0] readByte;

   assign pinsRaw = '{actionSelectHi, actionSelectLo, byteSelectLoHi, byteSelectSecond,
                      pageLatchStrobe, write_n, outputEnable_n, loadClockPin, dataIn};

   // Two-stage synchroniser on every pin, then a delayed copy for edges.
   // Reset loads the idle pin levels, so no false strobe or bus drive follows it.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1 <= `PPP_PINS_IDLE;
         sync2 <= `PPP_PINS_IDLE;
         prev <= `PPP_PINS_IDLE;
      end else begin
         sync1 <= pinsRaw;
         sync2 <= sync1;
         prev <= sync2;
      end
   end

   assign idle = (state == ST_IDLE);
   assign action = {sync2.actHi, sync2.actLo};
   assign fullAddr = {addrHi, addrLo};
   // Strobe edges count only while ready; busy periods ignore them.
   assign loadEvt = sync2.loadClock && !prev.loadClock && idle;  // [R27]
   assign latchEvt = sync2.pageLatch && !prev.pageLatch && idle && sync2.selLoHi;  // [R11] [R27]
   assign writeEvt = !sync2.write_n && prev.write_n && idle;  // [R27]
   assign readyBusyFlag = idle;  // [R23]

   // Command register holds until the next command load.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         command <= `PPP_CMD_NOP;
      end else if (loadEvt && action == `PPP_ACT_CMD && !sync2.selLoHi) begin
         command <= sync2.data;  // [R1] [R6]
      end
   end

   // Address and data byte loads; action 11 falls through as idle.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         addrLo <= '0;
         addrHi <= '0;
         dataLo <= '0;
         dataHi <= '0;
      end else if (loadEvt) begin
         unique case (action)
            `PPP_ACT_ADDR: begin
               if (sync2.selLoHi) addrHi <= sync2.data;  // [R9] [R1]
               else addrLo <= sync2.data;  // [R9]
            end
            `PPP_ACT_DATA: begin
               if (sync2.selLoHi) dataHi <= sync2.data;  // [R10]
               else dataLo <= sync2.data;  // [R10]
            end
            default: ;  // [R28]
         endcase
      end
   end

   // Page latches queue the word index and data into the FIFO.
   assign isEeprom = (command == `PPP_CMD_WR_EEPROM);
   assign fifoIn.index = isEeprom ? 5'(addrLo[`PPP_EEPROM_PAGE_BITS-1:0])
                                  : addrLo[`PPP_FLASH_PAGE_BITS-1:0];  // [R12]
   assign fifoIn.word = {dataHi, dataLo};
   assign fifoOutReady = (state == ST_IDLE) || (state == ST_DRAIN);

   ppp_fifo #(
      .WIDTH($bits(pageEntry_t)),
      .DEPTH(`PPP_FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .arst_n(arst_n),
      .inValid(latchEvt),
      .inReady(fifoInReady),
      .inData(fifoIn),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOut)
   );

   // Page buffer fills from the FIFO; a command load or a finished page empties it.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pageValid <= '0;
      end else if (loadEvt && action == `PPP_ACT_CMD && !sync2.selLoHi) begin
         pageValid <= '0;  // [R14] [R28]
      end else if (state == ST_PROG && walkDone) begin
         pageValid <= '0;  // [R28]
      end else if (fifoOutValid && fifoOutReady) begin
         pageValid[fifoOut.index] <= 1'b1;  // [R11]
      end
   end

   always_ff @(posedge clk) begin
      if (fifoOutValid && fifoOutReady) pageBuf[fifoOut.index] <= fifoOut.word;  // [R11]
   end

   // Operation sequencer: drains queued latches and times the busy period, drain included.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
         timer <= '0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               timer <= '0;
               if (writeEvt) begin
                  unique case (command)
                     `PPP_CMD_ERASE: state <= ST_ERASE;  // [R7]
                     `PPP_CMD_WR_FLASH, `PPP_CMD_WR_EEPROM: begin
                        if (!sync2.selLoHi) state <= ST_DRAIN;  // [R8] [R13] [R15]
                     end
                     `PPP_CMD_WR_FUSE, `PPP_CMD_WR_LOCK: state <= ST_PROG;  // [R18] [R19]
                     default: ;
                  endcase
               end
            end
            ST_DRAIN: begin
               timer <= timer + 21'h000001;
               if (!fifoOutValid) state <= ST_PROG;
            end
            ST_PROG: begin
               timer <= timer + 21'h000001;
               if (timer >= 21'(WRITE_CYCLES - 1)) state <= ST_IDLE;  // [R25]
            end
            ST_ERASE: begin
               timer <= timer + 21'h000001;
               if (timer >= 21'(ERASE_CYCLES - 1)) state <= ST_IDLE;  // [R26]
            end
         endcase
      end
   end

   // Walk index steps through the page or the flash array during busy.
   assign walkDone = (state == ST_PROG) ? (walkIdx == 12'(PAGE_WORDS - 1))
                                        : (walkIdx == 12'(`PPP_FLASH_WORDS - 1));
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         walkIdx <= '0;
      end else if ((state == ST_PROG || state == ST_ERASE) && !walkDone) begin
         walkIdx <= walkIdx + 12'h001;
      end else if (state == ST_IDLE) begin
         walkIdx <= '0;
      end
   end

   // Flash array: erase fills with ones, page programming writes loaded words.
   always_ff @(posedge clk) begin
      if (state == ST_ERASE) begin
         flashMem[walkIdx] <= `PPP_ERASED_WORD;  // [R3]
      end else if (state == ST_PROG && command == `PPP_CMD_WR_FLASH
                   && pageValid[walkIdx[4:0]] && walkIdx < 12'(PAGE_WORDS)) begin
         flashMem[{fullAddr[11:`PPP_FLASH_PAGE_BITS], walkIdx[4:0]}]
            <= pageBuf[walkIdx[4:0]];  // [R12] [R13]
      end
   end

   // Eeprom array: erased unless the preserve fuse is programmed.
   always_ff @(posedge clk) begin
      if (state == ST_ERASE && fuseHi[`PPP_PRESERVE_BIT]
          && walkIdx < 12'(`PPP_EEPROM_BYTES)) begin
         eepromMem[walkIdx[8:0]] <= `PPP_ERASED_BYTE;  // [R3] [R5]
      end else if (state == ST_PROG && isEeprom && walkIdx < 12'(4)
                   && pageValid[walkIdx[4:0]]) begin
         eepromMem[{fullAddr[8:`PPP_EEPROM_PAGE_BITS], walkIdx[1:0]}]
            <= pageBuf[walkIdx[4:0]][7:0];  // [R15]
      end
   end

   // Fuses change only by the fuse write; erase leaves them alone.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fuseLo <= FUSE_LO_RESET;
         fuseHi <= FUSE_HI_RESET;
      end else if (writeEvt && command == `PPP_CMD_WR_FUSE && !sync2.selSecond) begin
         if (sync2.selLoHi) fuseHi <= dataLo;  // [R18]
         else fuseLo <= dataLo;  // [R18]
      end
   end

   // Lock bits only gain programmed zeros; erase clears them after the flash walk.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lockBits <= LOCK_RESET;
      end else if (state == ST_ERASE && walkDone) begin
         lockBits <= `PPP_ERASED_BYTE;  // [R4] [R3]
      end else if (writeEvt && command == `PPP_CMD_WR_LOCK) begin
         lockBits <= lockBits & dataLo;  // [R19]
      end
   end

   // Read multiplexer chosen by command and byte selects.
   always_comb begin
      readByte = `PPP_ERASED_BYTE;
      unique case (command)
         `PPP_CMD_RD_FLASH: begin
            readByte = sync2.selLoHi ? flashMem[fullAddr[11:0]][15:8]
                                     : flashMem[fullAddr[11:0]][7:0];  // [R16]
         end
         `PPP_CMD_RD_EEPROM: begin
            if (!sync2.selLoHi) readByte = eepromMem[fullAddr[8:0]];  // [R17]
         end
         `PPP_CMD_RD_FUSE: begin
            unique case ({sync2.selSecond, sync2.selLoHi})
               2'h0: readByte = fuseLo;  // [R20]
               2'h3: readByte = fuseHi;  // [R20]
               2'h1: readByte = lockBits;  // [R20]
               default: readByte = `PPP_ERASED_BYTE;
            endcase
         end
         `PPP_CMD_RD_SIG: begin
            if (sync2.selLoHi) begin
               if (addrLo == 8'h00) readByte = CAL_BYTE;  // [R22]
            end else begin
               unique case (addrLo)
                  8'h00: readByte = ID_BYTE0;  // [R21]
                  8'h01: readByte = ID_BYTE1;  // [R21]
                  8'h02: readByte = ID_BYTE2;  // [R21]
                  default: readByte = `PPP_ERASED_BYTE;
               endcase
            end
         end
         default: readByte = `PPP_ERASED_BYTE;
      endcase
   end

   // Data bus drive follows the synchronised output enable.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dataOut <= '0;
         dataOe <= 1'b0;
      end else begin
         dataOut <= readByte;
         dataOe <= !sync2.outEnable_n;  // [R24]
      end
   end

   // Helper: length of the current busy period.
   logic [20:0] busyLen;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) busyLen <= '0;
      else if (idle) busyLen <= '0;
      else busyLen <= busyLen + 21'h000001;
   end
   logic wasErase;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) wasErase <= 1'b0;
      else if (state == ST_ERASE) wasErase <= 1'b1;
      else if (idle) wasErase <= 1'b0;
   end

   sequence sCmdLoad;
      loadEvt && action == `PPP_ACT_CMD && !sync2.selLoHi;
   endsequence
   sequence sEraseStart;
      writeEvt && command == `PPP_CMD_ERASE;
   endsequence

   a_erase_busy: assert property (@(posedge clk) disable iff (!arst_n)
      sEraseStart |=> !readyBusyFlag && state == ST_ERASE)  // [R7]
      else $error("Erase start did not drop the ready flag.");
   a_write_time: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(readyBusyFlag) && !$past(wasErase)
      |-> $past(busyLen) + 21'h000001 >= 21'(WRITE_CYCLES) && $past(busyLen) < 21'(WRITE_MAX))  // [R25]
      else $error("Write busy period out of range.");
   a_erase_time: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(readyBusyFlag) && $past(wasErase)
      |-> $past(busyLen) + 21'h000001 >= 21'(ERASE_CYCLES) && $past(busyLen) < 21'(ERASE_MAX))  // [R26]
      else $error("Erase busy period out of range.");
   a_lock_hold: assert property (@(posedge clk) disable iff (!arst_n)
      state == ST_ERASE && !walkDone |=> $stable(lockBits))  // [R4]
      else $error("Lock bits changed before the flash erase finished.");
   a_fuse_keep: assert property (@(posedge clk) disable iff (!arst_n)
      state == ST_ERASE |=> $stable(fuseLo) && $stable(fuseHi))  // [R3]
      else $error("Fuses changed during chip erase.");
   a_busy_ignore: assert property (@(posedge clk) disable iff (!arst_n)
      !idle |=> $stable(command) && $stable(addrLo) && $stable(addrHi) && $stable(dataLo))  // [R27]
      else $error("Register loaded while busy.");
   a_cmd_load: assert property (@(posedge clk) disable iff (!arst_n)
      sCmdLoad |=> command == $past(sync2.data) && pageValid == '0)  // [R6] [R14]
      else $error("Command load did not take effect.");
   a_addr_load: assert property (@(posedge clk) disable iff (!arst_n)
      loadEvt && action == `PPP_ACT_ADDR && !sync2.selLoHi |=> addrLo == $past(sync2.data))  // [R9]
      else $error("Address low byte not stored.");
   a_data_load: assert property (@(posedge clk) disable iff (!arst_n)
      loadEvt && action == `PPP_ACT_DATA && sync2.selLoHi |=> dataHi == $past(sync2.data))  // [R10]
      else $error("Data high byte not stored.");
   a_bus_drive: assert property (@(posedge clk) disable iff (!arst_n)
      dataOe |-> $past(sync2.outEnable_n) == 1'b0)  // [R24]
      else $error("Data bus driven without output enable.");
   a_cmd_hold: assert property (@(posedge clk) disable iff (!arst_n)
      !(loadEvt && action == `PPP_ACT_CMD && !sync2.selLoHi) |=> $stable(command))  // [R1]
      else $error("Command changed without a load.");
endmodule

// ===== sim/prog_model.sv
// Purpose: Programmer model that pulses the port's pins and times busy periods.
// Assumes: Every pin level is held four clock cycles.
// Notes: The data bus is inverted each step while the port owns it.
`timescale 1ns/10ps
module prog_model import ppp_pkg::*; (
   input wire logic clk,
   input wire logic ready,
   input wire logic [7:0] dout,
   input wire logic dOe,
   output pins_t p,
   output int busy
);
   // Idle pins: action idle, strobes inactive.
   initial begin
      p = 16'hC600;
      busy = 0;
   end
   // Counts the cycles that the ready flag stays low after a write strobe.
   always @(posedge clk) begin
      if (!p.write_n && ready)
         busy <= 0;
      else if (ready === 1'b0)
         busy <= busy + 1;
   end
   // Sets the pins just after an edge and holds them four cycles.
   task automatic step(pins_t v);
      @(posedge clk);
      p <= v;
      repeat (3) @(posedge clk);
   endtask
   // Pulses the strobes in the mask around a stable pin set.
   task automatic pulse(pins_t v, pins_t m);
      step(v);
      step(v ^ m);
      step(v);
   endtask
   // Waits for the ready flag under a bound.
   task automatic waitRdy();
      int n = 0;
      while (ready !== 1'b1 && n < 20000) begin
         @(posedge clk);
         n++;
      end
   endtask
   // Reads with output enable low, then samples the release of the bus.
   task automatic read(logic b1, logic b2, output logic [7:0] d, output logic [1:0] o);
      step({p[15:14], b1, b2, 4'h4, ~p.data});
      step({p[15:14], b1, b2, 4'h4, ~p.data});
      #1 {d, o[1]} = {dout, dOe};
      step({p[15:14], b1, b2, 4'h6, ~p.data});
      repeat (3) @(posedge clk);
      #1 o[0] = dOe;
   endtask
endmodule

// ===== sim/testbench.sv
// Purpose: Self-checking bench of the parallel programming port.
// Assumes: Short busy counts stand in for the millisecond ones.
// Notes: Page latches reach the page buffer through the design's own queue.
`timescale 1ns/10ps
module testbench import ppp_pkg::*;;
   localparam int WC = 64;
   localparam int EC = 5000;
   localparam logic [23:0] IDS = 24'h3BC496; // Arbitrary identification bytes.
   localparam logic [7:0] CAL = 8'h6D; // Arbitrary calibration value.
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic oe, rdy;
   logic [7:0] fLo = 8'hFF, fHi = 8'hFF, lk = 8'hFF, dout, b;
   logic [15:0] w;
   logic [15:0] fl [int];
   logic [7:0] ee [int];
   pins_t p;
   int busy, pg, num_errors = 0, n_tests = 0, seed = 32'h5896;
   initial forever #2.5 clk = ~clk;
   prog_model pm (.clk(clk), .ready(rdy), .dout(dout), .dOe(oe), .p(p), .busy(busy));
   parallel_program_port #(.WRITE_CYCLES(WC), .ERASE_CYCLES(EC), .ID_BYTE0(IDS[7:0]),
      .ID_BYTE1(IDS[15:8]), .ID_BYTE2(IDS[23:16]), .CAL_BYTE(CAL)) uut (.clk(clk),
      .arst_n(arst_n), .actionSelectHi(p.actHi), .actionSelectLo(p.actLo),
      .byteSelectLoHi(p.selLoHi), .byteSelectSecond(p.selSecond),
      .pageLatchStrobe(p.pageLatch), .write_n(p.write_n), .outputEnable_n(p.outEnable_n),
      .loadClockPin(p.loadClock), .dataIn(oe ? dout : p.data), .dataOut(dout),
      .dataOe(oe), .readyBusyFlag(rdy));
   task automatic check(logic [15:0] seen, logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (num_errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic ld(logic [1:0] a, logic b1, logic [7:0] d);
      pm.pulse({a, b1, 5'h06, d}, 16'h0100);
   endtask
   task automatic latch();
      pm.pulse({p[15:14], 6'h26, p[7:0]}, 16'h0800);
   endtask
   function automatic logic [7:0] ex(int a);
      return ee.exists(a) ? ee[a] : 8'hFF;
   endfunction
   task automatic rdchk(logic b1, logic b2, logic [7:0] e);
      logic [7:0] d;
      logic [1:0] o;
      pm.read(b1, b2, d, o);
      check(d, e);
      check(o, 2'b10);
   endtask
   task automatic rd2(int a);
      logic [15:0] v;
      v = fl.exists(a) ? fl[a] : 16'hFFFF;
      rdchk(1'b0, 1'b0, v[7:0]);
      rdchk(1'b1, 1'b0, v[15:8]);
   endtask
   // Strobes a write, tries a command load while busy, and times the busy period.
   task automatic wrchk(logic b1, int lo);
      pm.pulse({p[15:14], b1, 5'h06, p[7:0]}, 16'h0400);
      ld(2'b10, 1'b0, 8'h00);
      pm.waitRdy();
      check(lo ? busy >= lo - 1 && busy <= lo + lo / 5 : busy == 0, 1'b1);
   endtask
   task automatic erase();
      ld(2'b10, 1'b0, 8'h80);
      wrchk(1'b0, EC);
      fl.delete();
      lk = 8'hFF;
      if (fHi[3])
         ee.delete();
   endtask
   task automatic rdfuse();
      ld(2'b10, 1'b0, 8'h04);
      rdchk(1'b0, 1'b0, fLo);
      rdchk(1'b1, 1'b1, fHi);
      rdchk(1'b1, 1'b0, lk);
   endtask
   // Cuts a hung run short.
   initial begin
      #400000;
      num_errors++;
      complete_run();
   end
   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      #1 check({oe, rdy}, 2'b01);
      erase();
      ld(2'b10, 1'b0, 8'h10);
      pg = $random(seed) & 127;
      ld(2'b00, 1'b1, {4'h0, pg[6:3]});
      for (int i = 0; i < 32; i += 9) begin
         w = 16'($random(seed));
         fl[pg * 32 + i] = w;
         ld(2'b00, 1'b0, {pg[2:0], 5'(i)});
         ld(2'b01, 1'b0, w[7:0]);
         ld(2'b01, 1'b1, w[15:8]);
         ld(2'b11, 1'b0, 8'h00);
         latch();
      end
      wrchk(1'b0, WC);
      ld(2'b10, 1'b0, 8'h02);
      rd2(pg * 32 + 27);
      for (int i = 0; i < 32; i += 3) begin
         ld(2'b00, 1'b0, {pg[2:0], 5'(i)});
         rd2(pg * 32 + i);
      end
      ld(2'b10, 1'b0, 8'h10);
      ld(2'b01, 1'b0, 8'h00);
      latch();
      ld(2'b10, 1'b0, 8'h00);
      wrchk(1'b0, 0);
      ld(2'b10, 1'b0, 8'h02);
      rd2(pg * 32 + 30);
      ld(2'b10, 1'b0, 8'h11);
      ld(2'b00, 1'b1, 8'h01);
      for (int i = 320; i < 324; i++) begin
         ee[i] = 8'($random(seed));
         ld(2'b00, 1'b0, 8'(i));
         ld(2'b01, 1'b0, ee[i]);
         latch();
      end
      wrchk(1'b0, WC);
      ld(2'b10, 1'b0, 8'h03);
      for (int i = 320; i < 324; i++) begin
         ld(2'b00, 1'b0, 8'(i));
         rdchk(1'b0, 1'b0, ex(i));
      end
      fLo = 8'($random(seed));
      fHi = 8'($random(seed)) & 8'hF7;
      ld(2'b10, 1'b0, 8'h40);
      for (int i = 0; i < 2; i++) begin
         ld(2'b01, 1'b0, i ? fHi : fLo);
         wrchk(1'(i), WC);
      end
      b = 8'($random(seed));
      lk = b;
      ld(2'b10, 1'b0, 8'h20);
      ld(2'b01, 1'b0, b);
      wrchk(1'b0, WC);
      ld(2'b01, 1'b0, 8'hFF);
      wrchk(1'b0, WC);
      rdfuse();
      ld(2'b10, 1'b0, 8'h08);
      for (int i = 0; i < 3; i++) begin
         ld(2'b00, 1'b0, 8'(i));
         rdchk(1'b0, 1'b0, IDS[8 * i +: 8]);
      end
      ld(2'b00, 1'b0, 8'h00);
      rdchk(1'b1, 1'b0, CAL);
      erase();
      rdfuse();
      ld(2'b10, 1'b0, 8'h03);
      ld(2'b00, 1'b0, 8'h41);
      rdchk(1'b0, 1'b0, ex(321));
      ld(2'b10, 1'b0, 8'h02);
      ld(2'b00, 1'b1, {4'h0, pg[6:3]});
      ld(2'b00, 1'b0, {pg[2:0], 5'd9});
      rd2(pg * 32 + 9);
      // Fills a whole page through the latch queue and reads every word back.
      ld(2'b10, 1'b0, 8'h10);
      for (int i = 0; i < 32; i++) begin
         w = 16'($random(seed));
         fl[pg * 32 + i] = w;
         ld(2'b00, 1'b0, {pg[2:0], 5'(i)});
         ld(2'b01, 1'b0, w[7:0]);
         ld(2'b01, 1'b1, w[15:8]);
         latch();
      end
      wrchk(1'b0, WC);
      ld(2'b10, 1'b0, 8'h02);
      for (int i = 0; i < 32; i++) begin
         ld(2'b00, 1'b0, {pg[2:0], 5'(i)});
         rd2(pg * 32 + i);
      end
      check({oe, rdy}, 2'b01);
      complete_run();
   end
endmodule
